// ### src/flash_port_pkg.sv
// Package with the constants and types of the multi-lane flash port.
package flash_port_pkg;

  // Lane widths of a command phase; the value is bits per clock.
  typedef enum logic [2:0] {
    LANE_X1 = 3'h1,
    LANE_X2 = 3'h2,
    LANE_X4 = 3'h4
  } lanes_t;

  // Command shape supplied by the core after each instruction.
  typedef struct packed {
    lanes_t     addr_lanes;
    lanes_t     data_lanes;
    logic [2:0] addr_bytes;
    logic [4:0] dummy_clks;
    logic       is_read;
  } cmd_cfg_t;

  // One received byte of address or write data.
  typedef struct packed {
    logic [7:0] data;
    logic       is_addr;
  } rx_beat_t;

  // Command phases, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_OPC   = 3'h1,
    ST_CFG   = 3'h3,
    ST_ADDR  = 3'h2,
    ST_DUMMY = 3'h6,
    ST_DATA  = 3'h7
  } state_t;

  // Pin bundle layout: {lane3, lane2, lane1, lane0, select_n, sck}.
  localparam int         PIN_W     = 6;
  localparam int         PIN_SCK   = 0;
  localparam int         PIN_SEL   = 1;
  localparam int         PIN_LANE  = 2;
  // Pins rest with select high and the pulled-up lanes 2 and 3 high.
  localparam logic [5:0] PIN_RST   = 6'h32;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] OE_OFF    = 4'hf;

endpackage : flash_port_pkg

// ### src/pin_sync.sv
// Two-stage synchroniser for the pins that arrive from the host.
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  input  wire logic [flash_port_pkg::PIN_W-1:0] pins,
  output logic      [flash_port_pkg::PIN_W-1:0] pins_s
);
  import flash_port_pkg::*;

  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] sync_r;

  // The first stage feeds only the second one; metastability settles between them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= PIN_RST;
      sync_r <= PIN_RST;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  assign pins_s = sync_r;

endmodule : pin_sync

`default_nettype wire

// ### src/spi_multi_io_flash_port.sv
// Pin-level serial port of a flash memory with single, dual and quad lanes.
`timescale 1ns/100ps
`default_nettype none

module spi_multi_io_flash_port (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     sck,
  input  wire logic                     device_select_n,
  input  wire logic [3:0]               lane_in,
  output logic      [3:0]               lane_out,
  output logic      [3:0]               lane_oe_n,
  input  wire logic                     quad_enable,
  input  wire logic                     busy,
  input  wire flash_port_pkg::cmd_cfg_t cfg,
  input  wire logic [7:0]               tx_data,
  output logic      [7:0]               opcode,
  output logic                          opcode_stb,
  output flash_port_pkg::rx_beat_t      rx_beat,
  output logic                          rx_stb,
  output logic                          tx_take,
  output logic                          cmd_done,
  output logic                          write_protect_n,
  output logic                          paused,
  output logic                          standby
);
  import flash_port_pkg::*;

  // Shift the incoming lanes into a byte, most significant bits first.
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] p,
                                          input lanes_t w);
    case (w)
      LANE_X2: shift_in = {s[5:0], p[1:0]};
      LANE_X4: shift_in = {s[3:0], p};
      default: shift_in = {s[6:0], p[0]};
    endcase
  endfunction : shift_in

  // Place the top bits of a byte on the lanes; serial data leaves on lane 1.
  function automatic logic [3:0] lane_drive(input logic [7:0] b, input lanes_t w);
    case (w)
      LANE_X2: lane_drive = {2'h0, b[7:6]};
      LANE_X4: lane_drive = b[7:4];
      default: lane_drive = {2'h0, b[7], 1'b0};
    endcase
  endfunction : lane_drive

  // Drop the bits just placed on the lanes.
  function automatic logic [7:0] shift_out(input logic [7:0] b, input lanes_t w);
    case (w)
      LANE_X2: shift_out = {b[5:0], 2'h0};
      LANE_X4: shift_out = {b[3:0], 4'h0};
      default: shift_out = {b[6:0], 1'b0};
    endcase
  endfunction : shift_out

  // Active-low enables of the lanes that carry read data.
  function automatic logic [3:0] oe_mask(input lanes_t w);
    case (w)
      LANE_X2: oe_mask = 4'hc;
      LANE_X4: oe_mask = 4'h0;
      default: oe_mask = 4'hd;
    endcase
  endfunction : oe_mask

  logic [PIN_W-1:0] pins_s;
  logic             sck_d_r;
  logic             sel_n_d_r;
  logic [1:0]       flush_r;
  logic             armed_r;
  state_t           state_r;
  state_t           state_nxt;
  cmd_cfg_t         cfg_r;
  logic [7:0]       sreg_r;
  logic [3:0]       bit_cnt_r;
  logic [2:0]       byte_cnt_r;
  logic [4:0]       dum_cnt_r;
  logic [7:0]       txs_r;
  logic [3:0]       tx_left_r;
  logic             drive_en_r;
  logic [3:0]       lane_out_r;
  logic [3:0]       lane_oe_n_r;
  logic [7:0]       opcode_r;
  logic             opcode_stb_r;
  rx_beat_t         rx_beat_r;
  logic             rx_stb_r;
  logic             tx_take_r;
  logic             cmd_done_r;
  logic             wp_n_r;
  logic             paused_r;
  logic             standby_r;

  // Every pin from the host crosses into the clk domain first.
  pin_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pins    ({lane_in, device_select_n, sck}),
    .pins_s  (pins_s)
  );

  // Select and clock edges; the port is deaf while deselected or paused.
  wire       sck_s    = pins_s[PIN_SCK];
  wire       sel_n_s  = pins_s[PIN_SEL];
  wire [3:0] lane_s   = pins_s[PIN_LANE +: 4];
  wire       sel      = ~sel_n_s;
  wire       sel_fall = ~sel_n_s & sel_n_d_r & armed_r;
  wire       sel_rise = sel_n_s & ~sel_n_d_r;
  wire       live     = sel & ~paused_r;
  wire       rise     = live & sck_s & ~sck_d_r;
  wire       fall     = live & ~sck_s & sck_d_r;

  // Phase decode shared by the shifters and the pin functions.
  wire    in_opc    = state_r == ST_OPC;
  wire    in_addr   = state_r == ST_ADDR;
  wire    in_dummy  = state_r == ST_DUMMY;
  wire    in_data   = state_r == ST_DATA;
  wire    rd_phase  = in_data & cfg_r.is_read;
  wire    wr_phase  = in_data & ~cfg_r.is_read;
  wire    quad_cmd  = (in_addr | in_dummy | in_data)
                      & (cfg_r.addr_lanes == LANE_X4 | cfg_r.data_lanes == LANE_X4);
  // The instruction is always serial on lane 0.
  wire lanes_t in_w = in_opc ? LANE_X1
                    : in_addr ? cfg_r.addr_lanes : cfg_r.data_lanes;
  wire [3:0] bit_sum  = bit_cnt_r + {1'b0, in_w};
  wire       byte_end = bit_sum == BYTE_BITS;
  wire       take_in  = rise & (in_opc | in_addr | wr_phase);
  wire [7:0] sreg_in  = shift_in(sreg_r, lane_s, in_w);
  wire       addr_end = rise & in_addr & byte_end
                        & (byte_cnt_r == cfg_r.addr_bytes - 3'h1);
  wire       dum_end  = rise & in_dummy & (dum_cnt_r == cfg_r.dummy_clks - 5'h1);
  wire       tx_empty = tx_left_r == 4'h0;
  wire [7:0] tx_word  = tx_empty ? tx_data : txs_r;
  wire lanes_t out_w  = cfg_r.data_lanes;

  // Phase sequencing; a deselect always ends the command.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (sel_fall) state_nxt = ST_OPC;
      ST_OPC:   if (rise && byte_end) state_nxt = ST_CFG;
      ST_CFG: begin
        if (cfg.addr_bytes != 3'h0) state_nxt = ST_ADDR;
        else if (cfg.dummy_clks != 5'h0) state_nxt = ST_DUMMY;
        else state_nxt = ST_DATA;
      end
      ST_ADDR: begin
        if (addr_end) state_nxt = (cfg_r.dummy_clks != 5'h0) ? ST_DUMMY : ST_DATA;
      end
      ST_DUMMY: if (dum_end) state_nxt = ST_DATA;
      ST_DATA:  state_nxt = ST_DATA;
      default:  state_nxt = ST_IDLE;
    endcase
    if (sel_n_s) state_nxt = ST_IDLE;
  end

  // Edge history and phase register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_d_r   <= 1'b0;
      sel_n_d_r <= 1'b1;
      state_r   <= ST_IDLE;
    end else begin
      sck_d_r   <= sck_s;
      sel_n_d_r <= sel_n_s;
      state_r   <= state_nxt;
    end
  end

  // The synchroniser shows its rest values for two cycles after reset.
  // A select that was already low would then look like a fresh fall, so the
  // port arms only once it has seen a real high level on the select pin.
  // The cost is that a host must raise select once before its first command.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flush_r <= 2'h0;
      armed_r <= 1'b0;
    end else begin
      flush_r <= {flush_r[0], 1'b1};
      if (flush_r[1] && sel_n_s) armed_r <= 1'b1;
    end
  end

  // The core answers the instruction strobe with the command shape.
  always_ff @(posedge clk) begin
    if (sys_rst) cfg_r <= '0;
    else if (state_r == ST_CFG) cfg_r <= cfg;
  end

  // Input shifter and bit counter, advanced on rising clock only.
  always_ff @(posedge clk) begin
    if (sys_rst || !(in_opc || in_addr || wr_phase)) begin
      sreg_r    <= 8'h00;
      bit_cnt_r <= 4'h0;
    end else if (take_in) begin
      sreg_r    <= sreg_in;
      bit_cnt_r <= byte_end ? 4'h0 : bit_sum;
    end
  end

  // Address byte and dummy clock counters.
  always_ff @(posedge clk) begin
    if (sys_rst || !in_addr) byte_cnt_r <= 3'h0;
    else if (rise && byte_end) byte_cnt_r <= byte_cnt_r + 3'h1;
    if (sys_rst || !in_dummy) dum_cnt_r <= 5'h0;
    else if (rise) dum_cnt_r <= dum_cnt_r + 5'h1;
  end

  // Received instruction and data bytes go to the core as strobes.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opcode_r     <= 8'h00;
      opcode_stb_r <= 1'b0;
      rx_beat_r    <= '0;
      rx_stb_r     <= 1'b0;
    end else begin
      opcode_stb_r <= take_in & in_opc & byte_end;
      rx_stb_r     <= take_in & ~in_opc & byte_end;
      if (take_in && in_opc && byte_end) opcode_r <= sreg_in;
      if (take_in && !in_opc && byte_end) rx_beat_r <= '{data: sreg_in, is_addr: in_addr};
    end
  end

  // Read data moves only after a falling clock, ready for the next rise.
  // A fresh byte is taken from the core whenever the shifter runs dry.
  always_ff @(posedge clk) begin
    if (sys_rst || !rd_phase) begin
      txs_r      <= 8'h00;
      tx_left_r  <= 4'h0;
      lane_out_r <= 4'h0;
      drive_en_r <= 1'b0;
      tx_take_r  <= 1'b0;
    end else begin
      tx_take_r <= fall & tx_empty;
      if (fall) begin
        lane_out_r <= lane_drive(tx_word, out_w);
        txs_r      <= shift_out(tx_word, out_w);
        tx_left_r  <= (tx_empty ? BYTE_BITS : tx_left_r) - {1'b0, out_w};
        drive_en_r <= 1'b1;
      end
    end
  end

  // Lanes float unless selected, unpaused and in the read data phase.
  // The held bit reappears after a pause because the shifter stood still.
  always_ff @(posedge clk) begin
    if (sys_rst) lane_oe_n_r <= OE_OFF;
    else if (sel && !paused_r && rd_phase && (drive_en_r || fall))
      lane_oe_n_r <= oe_mask(out_w);
    else lane_oe_n_r <= OE_OFF;
  end

  // The pause pin only acts outside quad commands, and only while sck is low.
  always_ff @(posedge clk) begin
    if (sys_rst || !sel) paused_r <= 1'b0;
    else if (!sck_s) paused_r <= ~lane_s[3] & ~quad_cmd;
  end

  // Write protect level for the protection logic; quad use overrides it.
  always_ff @(posedge clk) begin
    if (sys_rst) wp_n_r <= 1'b1;
    else wp_n_r <= (quad_enable | quad_cmd) ? 1'b1 : lane_s[2];
  end

  // Power state and command end; internal operations ride through a pause.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standby_r  <= 1'b1;
      cmd_done_r <= 1'b0;
    end else begin
      standby_r  <= sel_n_s & ~busy;
      cmd_done_r <= sel_rise;
    end
  end

  // All outputs come straight from flip-flops.
  assign lane_out        = lane_out_r;
  assign lane_oe_n       = lane_oe_n_r;
  assign opcode          = opcode_r;
  assign opcode_stb      = opcode_stb_r;
  assign rx_beat         = rx_beat_r;
  assign rx_stb          = rx_stb_r;
  assign tx_take         = tx_take_r;
  assign cmd_done        = cmd_done_r;
  assign write_protect_n = wp_n_r;
  assign paused          = paused_r;
  assign standby         = standby_r;

endmodule : spi_multi_io_flash_port

`default_nettype wire

// ### verification/flash_port_chk.sv
// Concurrent checks on the pins and status outputs of the flash serial port.
`timescale 1ns/100ps
`default_nettype none

module flash_port_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       sck,
  input wire logic       device_select_n,
  input wire logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe_n,
  input wire logic       quad_enable,
  input wire logic       busy,
  input wire logic       opcode_stb,
  input wire logic       rx_stb,
  input wire logic       write_protect_n,
  input wire logic       paused,
  input wire logic       standby
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Pins pass two sync stages, so every window allows for that lag.
  sequence desel_s;
    device_select_n [*4];
  endsequence
  chk_desel_hiz: assert property (desel_s |-> lane_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  chk_desel_quiet: assert property (desel_s |-> !opcode_stb && !rx_stb)
    else $error("strobe while deselected");
  chk_launch_fall: assert property ($changed(lane_out) |-> !$past(sck, 2))
    else $error("output changed while clock high");
  chk_standby_busy: assert property (busy |=> !standby)
    else $error("standby during internal operation");
  chk_standby_idle: assert property ((device_select_n && !busy) [*5] |-> standby)
    else $error("no standby when idle");
  chk_active_sel: assert property (!device_select_n [*5] |-> !standby)
    else $error("standby while selected");
  chk_wp_quad: assert property (quad_enable |=> write_protect_n)
    else $error("write protect active in quad mode");
  chk_wp_follow: assert property ((!quad_enable && !lane_in[2]) [*4] |-> !write_protect_n)
    else $error("write protect pin not followed");
  chk_pause_hiz: assert property (paused && $past(paused) |-> lane_oe_n[1])
    else $error("output driven while paused");
  chk_pause_low: assert property ($rose(paused) |-> !$past(sck, 3) && !$past(lane_in[3], 3))
    else $error("pause began with clock high");
endmodule : flash_port_chk

bind spi_multi_io_flash_port flash_port_chk u_chk (
  .clk, .sys_rst, .sck, .device_select_n, .lane_in, .lane_out, .lane_oe_n, .quad_enable,
  .busy, .opcode_stb, .rx_stb, .write_protect_n, .paused, .standby
);

`default_nettype wire

// ### verification/spi_host_model.sv
// Mode 0 host master that frames commands on the flash port's pins.
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] lanes,
  output logic            sck,
  output logic            sel_n,
  output logic [3:0]      drv,
  output logic [3:0]      drv_en
);
  logic hold_r;

  // Select starts low so the power-up rule is exercised; the clock rests low.
  initial begin
    sck = 1'b0;
    sel_n = 1'b0;
    drv = 4'h0;
    drv_en = 4'h0;
    hold_r = 1'b0;
  end

  // Half a link clock period, moving pins just after a system clock edge.
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask : half

  task automatic sel(input logic v);
    half();
    sel_n = v;
  endtask : sel

  // Pause is asked for with the clock low and given time to be seen.
  task automatic hold(input logic v);
    hold_r = v;
    drv_en[3] = v;
    half();
    half();
  endtask : hold

  // Bits go out before a rise and are taken at the rise, MSB first.
  task automatic shift(input logic [7:0] tx, input int w, input logic rd,
                       output logic [7:0] rx);
    logic [7:0] s;
    s = tx;
    for (int i = 0; i < 8 / w; i++) begin
      drv_en = (rd ? 4'h0 : (4'h1 << w) - 4'h1) | {hold_r, 3'h0};
      drv = (w == 4) ? s[7:4] : (w == 2) ? {2'h0, s[7:6]} : {3'h0, s[7]};
      half();
      sck = 1'b1;
      rx = (w == 4) ? {rx[3:0], lanes} : (w == 2) ? {rx[5:0], lanes[1:0]} : {rx[6:0], lanes[1]};
      s = s << w;
      half();
      sck = 1'b0;
    end
  endtask : shift
endmodule : spi_host_model

`default_nettype wire

// ### verification/test_spi_multi_io_flash_port.sv
// Self-checking bench of the multi-lane flash serial port.
`timescale 1ns/100ps
`default_nettype none

module test_spi_multi_io_flash_port;
  import flash_port_pkg::*;
  logic       clk, sys_rst, sck, device_select_n, quad_enable, busy, flt;
  logic       opcode_stb, rx_stb, tx_take, cmd_done, write_protect_n, paused, standby;
  logic [3:0] lane_in, lane_out, lane_oe_n, drv, drv_en;
  logic [7:0] tx_data, opcode, n_op;
  cmd_cfg_t   cfg;
  rx_beat_t   rx_beat;
  rx_beat_t   rx_q[$];
  int         n_fail, checked, busy_cnt;

  // Length of the internal program that follows a write command.
  localparam int BUSY_CLKS = 10;

  // Undriven data lanes wander each cycle; lanes 2 and 3 have pull-ups.
  assign lane_in = (~lane_oe_n & lane_out) | (lane_oe_n & drv_en & drv)
                 | (lane_oe_n & ~drv_en & {2'h3, flt, flt});

  spi_multi_io_flash_port i_dut (
    .clk, .sys_rst, .sck, .device_select_n, .lane_in, .lane_out, .lane_oe_n, .quad_enable,
    .busy, .cfg, .tx_data, .opcode, .opcode_stb, .rx_beat, .rx_stb, .tx_take, .cmd_done,
    .write_protect_n, .paused, .standby
  );
  spi_host_model u_host (.clk, .lanes(lane_in), .sck, .sel_n(device_select_n), .drv, .drv_en);

  always #50 clk = ~clk;

  // Core decode of the received instruction into the command shape.
  function automatic cmd_cfg_t cfg_of(input logic [7:0] op);
    case (op)
      8'h02:   cfg_of = '{LANE_X1, LANE_X1, 3'h1, 5'h00, 1'b0};
      8'h03:   cfg_of = '{LANE_X1, LANE_X1, 3'h1, 5'h00, 1'b1};
      8'h3b:   cfg_of = '{LANE_X1, LANE_X2, 3'h1, 5'h00, 1'b1};
      8'heb:   cfg_of = '{LANE_X4, LANE_X4, 3'h1, 5'h02, 1'b1};
      default: cfg_of = '{LANE_X1, LANE_X1, 3'h0, 5'h00, 1'b0};
    endcase
  endfunction : cfg_of

  // The shape follows the instruction, so a wrong opcode shows up as a wrong shape.
  assign cfg  = cfg_of(opcode);
  assign busy = busy_cnt != 0;

  // Core side: count strobes, keep beats, present the next read byte and
  // run an internal program once a write command has ended.
  always @(posedge clk) begin
    flt <= ~flt;
    if (opcode_stb === 1'b1) n_op <= n_op + 8'h1;
    if (rx_stb === 1'b1) rx_q.push_back(rx_beat);
    if (tx_take === 1'b1) tx_data <= tx_data + 8'h11;
    if (cmd_done === 1'b1 && opcode === 8'h02) busy_cnt <= BUSY_CLKS;
    else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
  end

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_done();
    int i;
    for (i = 0; i < 40; i++) begin
      tick(1);
      if (cmd_done === 1'b1) break;
    end
    if (i == 40) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_done

  // Select held low through reset must not open a command.
  task automatic sc_powerup();
    logic [7:0] r;
    u_host.shift(8'h03, 1, 1'b0, r);
    cmp("opcode strobes", 8'h0, n_op);
    cmp("lane enables", 8'hf, {4'h0, lane_oe_n});
    u_host.sel(1'b1);
    u_host.drv_en = 4'h4;
    u_host.drv = 4'h0;
    tick(6);
    cmp("write protect", 8'h0, {7'h0, write_protect_n});
    quad_enable = 1'b1;
    tick(3);
    cmp("write protect", 8'h1, {7'h0, write_protect_n});
    quad_enable = 1'b0;
    u_host.drv_en = 4'h0;
    tick(6);
    cmp("standby", 8'h1, {7'h0, standby});
  endtask : sc_powerup

  // Bits of a write clocked during a pause must be lost; the rest of the write goes through.
  task automatic sc_write_pause();
    logic [7:0] r;
    rx_q.delete();
    n_op = 8'h0;
    u_host.sel(1'b0);
    u_host.shift(8'h02, 1, 1'b0, r);
    u_host.hold(1'b1);
    cmp("paused", 8'h1, {7'h0, paused});
    u_host.shift(8'hff, 1, 1'b0, r);
    u_host.hold(1'b0);
    u_host.shift(8'h5a, 1, 1'b0, r);
    u_host.shift(8'hc3, 1, 1'b0, r);
    cmp("standby", 8'h0, {7'h0, standby});
    u_host.sel(1'b1);
    wait_done();
    tick(3);
    cmp("standby", 8'h0, {7'h0, standby});
    tick(12);
    cmp("standby", 8'h1, {7'h0, standby});
    cmp("opcode", 8'h02, opcode);
    cmp("opcode strobes", 8'h1, n_op);
    cmp("beats", 8'h2, 8'(rx_q.size()));
    cmp("address beat", 8'h5a, rx_q[0].data);
    cmp("address flag", 8'h1, {7'h0, rx_q[0].is_addr});
    cmp("data beat", 8'hc3, rx_q[1].data);
  endtask : sc_write_pause

  // One read of two bytes; lanes stay off until the data phase.
  task automatic rd_cmd(input logic [7:0] op, input cmd_cfg_t c, input logic [7:0] t0);
    logic [7:0] r;
    tx_data = t0;
    u_host.sel(1'b0);
    u_host.shift(op, 1, 1'b0, r);
    u_host.shift(8'h5a, int'(c.addr_lanes), 1'b0, r);
    if (c.dummy_clks != 5'h0) u_host.shift(8'h00, 8 / int'(c.dummy_clks), 1'b1, r);
    cmp("lane enables", 8'hf, {4'h0, lane_oe_n});
    u_host.shift(8'h00, int'(c.data_lanes), 1'b1, r);
    cmp("first read byte", t0, r);
    u_host.shift(8'h00, int'(c.data_lanes), 1'b1, r);
    cmp("second read byte", t0 + 8'h11, r);
    u_host.sel(1'b1);
    wait_done();
    cmp("opcode", op, opcode);
  endtask : rd_cmd

  // Reads at every lane width, quad with the third and fourth pins as data.
  task automatic sc_reads();
    rd_cmd(8'h03, '{LANE_X1, LANE_X1, 3'h1, 5'h00, 1'b1}, 8'ha5);
    rd_cmd(8'h3b, '{LANE_X1, LANE_X2, 3'h1, 5'h00, 1'b1}, 8'h96);
    quad_enable = 1'b1;
    rd_cmd(8'heb, '{LANE_X4, LANE_X4, 3'h1, 5'h02, 1'b1}, 8'h3c);
    quad_enable = 1'b0;
  endtask : sc_reads

  initial begin
    clk = 1'b0;
    flt = 1'b0;
    sys_rst = 1'b1;
    quad_enable = 1'b0;
    busy_cnt = 0;
    tx_data = 8'h00;
    n_op = 8'h0;
    n_fail = 0;
    checked = 0;
    tick(20);
    sys_rst = 1'b0;
    sc_powerup();
    sc_write_pause();
    sc_reads();
    report_and_stop();
  end
endmodule : test_spi_multi_io_flash_port

`default_nettype wire
